// ==== bma_alu.v ====
`timescale 1ns/1ps
`include "bma_defines.vh"
////////////////////////////////////////////////////////////////////////////////
// Bit-manipulation execution unit, one-cycle registered result
module bma_alu (
	// Clock and reset
	input wire i_clk,
	input wire i_rst,
	// Request
	input wire i_valid,
	input wire [5:0] i_op,
	input wire i_rv64,
	input wire [63:0] i_rs1,
	input wire [63:0] i_rs2,
	input wire [6:0] i_imm,
	// Result
	output reg o_valid,
	output reg o_illegal,
	output reg [63:0] o_result
);
	////////////////////////////////////////////////////////////////////////////////
	// Helpers
	function [6:0] f_clz;
		input [63:0] v;
		input [6:0] w;
		integer k;
		reg done;
		begin
			f_clz = w;
			done = 1'b0;
			for (k = 63; k >= 0; k = k - 1) begin
				if (!done && k < w && v[k]) begin
					f_clz = w - 7'd1 - k[6:0];
					done = 1'b1;
				end
			end
		end
	endfunction
	function [6:0] f_ctz;
		input [63:0] v;
		input [6:0] w;
		integer k;
		reg done;
		begin
			f_ctz = w;
			done = 1'b0;
			for (k = 0; k < 64; k = k + 1) begin
				if (!done && k < w && v[k]) begin
					f_ctz = k[6:0];
					done = 1'b1;
				end
			end
		end
	endfunction
	function [6:0] f_cpop;
		input [63:0] v;
		integer k;
		begin
			f_cpop = 7'd0;
			for (k = 0; k < 64; k = k + 1) begin
				f_cpop = f_cpop + {6'd0, v[k]};
			end
		end
	endfunction
	// Sign-extend low word
	function [63:0] f_sxw;
		input [31:0] v;
		begin
			f_sxw = {{32{v[31]}}, v};
		end
	endfunction
	// Width-aware rotate right
	function [63:0] f_ror;
		input [63:0] v;
		input [5:0] s;
		input rv64;
		reg [127:0] d;
		reg [63:0] t;
		begin
			if (rv64) begin
				d = {v, v} >> s;
				f_ror = d[63:0];
			end else begin
				t = {v[31:0], v[31:0]} >> s[4:0];
				f_ror = f_sxw(t[31:0]);
			end
		end
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	// Operand preparation
	wire [63:0] a = i_rv64 ? i_rs1 : f_sxw(i_rs1[31:0]);
	wire [63:0] b = i_rv64 ? i_rs2 : f_sxw(i_rs2[31:0]);
	wire [63:0] a_uw = {32'h0000_0000, i_rs1[31:0]};
	wire [6:0] xw = i_rv64 ? 7'd64 : 7'd32;
	wire [5:0] rmask = i_rv64 ? 6'h3f : 6'h1f;
	wire [5:0] ramt = i_rs2[5:0] & rmask;
	wire [5:0] iamt = i_imm[5:0];
	wire [5:0] ridx = i_rs2[5:0] & rmask;
	wire [127:0] prod;
	bma_clmul u_clmul (
		.i_a(a),
		.i_b(b),
		.i_rv64(i_rv64),
		.o_prod(prod)
	);
	////////////////////////////////////////////////////////////////////////////////
	// Result selection, one shared path per operation
	reg [63:0] next_result;
	reg next_illegal;
	reg [63:0] one_hot;
	reg [5:0] sidx;
	reg [63:0] tmp;
	integer j;
	always @* begin
		next_result = 64'h0000_0000_0000_0000;
		next_illegal = 1'b0;
		sidx = (i_op == `BMA_OP_BCLR || i_op == `BMA_OP_BEXT || i_op == `BMA_OP_BINV
			|| i_op == `BMA_OP_BSET) ? ridx : iamt;
		one_hot = 64'h0000_0000_0000_0001 << sidx;
		tmp = 64'h0000_0000_0000_0000;
		case (i_op)
			`BMA_OP_ADDUW: next_result = i_rs2 + a_uw;
			`BMA_OP_SH1ADD: next_result = b + (a << 1);
			`BMA_OP_SH2ADD: next_result = b + (a << 2);
			`BMA_OP_SH3ADD: next_result = b + (a << 3);
			`BMA_OP_SH1ADDUW: next_result = i_rs2 + (a_uw << 1);
			`BMA_OP_SH2ADDUW: next_result = i_rs2 + (a_uw << 2);
			`BMA_OP_SH3ADDUW: next_result = i_rs2 + (a_uw << 3);
			`BMA_OP_SLLIUW: next_result = a_uw << iamt;
			`BMA_OP_ANDN: next_result = a & ~b;
			`BMA_OP_ORN: next_result = a | ~b;
			`BMA_OP_XNOR: next_result = ~(a ^ b);
			`BMA_OP_CLZ: next_result = {57'd0, f_clz(a, xw)};
			`BMA_OP_CLZW: next_result = {57'd0, f_clz(a_uw, 7'd32)};
			`BMA_OP_CTZ: next_result = {57'd0, f_ctz(a, xw)};
			`BMA_OP_CTZW: next_result = {57'd0, f_ctz(a_uw, 7'd32)};
			`BMA_OP_CPOP: next_result = {57'd0, f_cpop(i_rv64 ? a : a_uw)};
			`BMA_OP_CPOPW: next_result = {57'd0, f_cpop(a_uw)};
			`BMA_OP_MAX: next_result = ($signed(a) > $signed(b)) ? a : b;
			`BMA_OP_MAXU: next_result = (a > b) ? a : b;
			`BMA_OP_MIN: next_result = ($signed(a) < $signed(b)) ? a : b;
			`BMA_OP_MINU: next_result = (a < b) ? a : b;
			`BMA_OP_SEXTB: next_result = {{56{i_rs1[7]}}, i_rs1[7:0]};
			`BMA_OP_SEXTH: next_result = {{48{i_rs1[15]}}, i_rs1[15:0]};
			`BMA_OP_ZEXTH: next_result = {48'd0, i_rs1[15:0]};
			`BMA_OP_ROL: next_result = f_ror(a, (6'd0 - ramt) & rmask, i_rv64);
			`BMA_OP_ROR: next_result = f_ror(a, ramt, i_rv64);
			`BMA_OP_RORI: begin
				next_result = f_ror(a, iamt & rmask, i_rv64);
				next_illegal = !i_rv64 && iamt[5];
			end
			`BMA_OP_ROLW: next_result = f_ror(a, (6'd0 - i_rs2[5:0]) & 6'h1f, 1'b0);
			`BMA_OP_RORW: next_result = f_ror(a, i_rs2[5:0] & 6'h1f, 1'b0);
			`BMA_OP_RORIW: begin
				next_result = f_ror(a, iamt & 6'h1f, 1'b0);
				next_illegal = !i_rv64 || iamt[5];
			end
			`BMA_OP_ORCB: begin
				for (j = 0; j < 8; j = j + 1) begin
					tmp[j*8 +: 8] = {8{|a[j*8 +: 8]}};
				end
				next_result = i_rv64 ? tmp : f_sxw(tmp[31:0]);
			end
			`BMA_OP_REV8: begin
				for (j = 0; j < 8; j = j + 1) begin
					tmp[j*8 +: 8] = a[(7-j)*8 +: 8];
				end
				next_result = i_rv64 ? tmp : f_sxw({a[7:0], a[15:8], a[23:16], a[31:24]});
			end
			`BMA_OP_CLMUL: next_result = i_rv64 ? prod[63:0] : f_sxw(prod[31:0]);
			`BMA_OP_CLMULH: next_result = i_rv64 ? prod[127:64] : f_sxw(prod[63:32]);
			`BMA_OP_CLMULR: next_result = i_rv64 ? prod[126:63] : f_sxw(prod[62:31]);
			`BMA_OP_BCLR, `BMA_OP_BCLRI: next_result = a & ~one_hot;
			`BMA_OP_BINV, `BMA_OP_BINVI: next_result = a ^ one_hot;
			`BMA_OP_BSET, `BMA_OP_BSETI: next_result = a | one_hot;
			`BMA_OP_BEXT, `BMA_OP_BEXTI: next_result = {63'd0, |(a & one_hot)};
			default: next_illegal = 1'b1;
		endcase
		// 64-bit-only forms and oversize immediates
		if (!i_rv64 && (i_op == `BMA_OP_ADDUW || i_op == `BMA_OP_SH1ADDUW
			|| i_op == `BMA_OP_SH2ADDUW || i_op == `BMA_OP_SH3ADDUW
			|| i_op == `BMA_OP_SLLIUW || i_op == `BMA_OP_CLZW || i_op == `BMA_OP_CTZW
			|| i_op == `BMA_OP_CPOPW || i_op == `BMA_OP_ROLW || i_op == `BMA_OP_RORW)) begin
			next_illegal = 1'b1;
		end
		if (i_imm[6]) begin
			next_illegal = 1'b1;
		end
		if (!i_rv64 && iamt[5] && (i_op == `BMA_OP_BCLRI || i_op == `BMA_OP_BEXTI
			|| i_op == `BMA_OP_BINVI || i_op == `BMA_OP_BSETI)) begin
			next_illegal = 1'b1;
		end
		// 32-bit hart results follow bit 31
		if (!i_rv64) begin
			next_result = f_sxw(next_result[31:0]);
		end
		if (next_illegal) begin
			next_result = 64'h0000_0000_0000_0000;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Output stage, no state kept across instructions
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_valid <= 1'b0;
			o_illegal <= 1'b0;
			o_result <= 64'h0000_0000_0000_0000;
		end else begin
			o_valid <= i_valid;
			o_illegal <= i_valid & next_illegal;
			o_result <= i_valid ? next_result : 64'h0000_0000_0000_0000;
		end
	end
endmodule // bma_alu

// ==== bma_defines.vh ====
`ifndef BMA_DEFINES_VH
`define BMA_DEFINES_VH
`define BMA_XLEN 64
`define BMA_OPW 6
`define BMA_OP_ADDUW 6'h00
`define BMA_OP_SH1ADD 6'h01
`define BMA_OP_SH2ADD 6'h02
`define BMA_OP_SH3ADD 6'h03
`define BMA_OP_SH1ADDUW 6'h04
`define BMA_OP_SH2ADDUW 6'h05
`define BMA_OP_SH3ADDUW 6'h06
`define BMA_OP_SLLIUW 6'h07
`define BMA_OP_ANDN 6'h08
`define BMA_OP_ORN 6'h09
`define BMA_OP_XNOR 6'h0a
`define BMA_OP_CLZ 6'h0b
`define BMA_OP_CLZW 6'h0c
`define BMA_OP_CTZ 6'h0d
`define BMA_OP_CTZW 6'h0e
`define BMA_OP_CPOP 6'h0f
`define BMA_OP_CPOPW 6'h10
`define BMA_OP_MAX 6'h11
`define BMA_OP_MAXU 6'h12
`define BMA_OP_MIN 6'h13
`define BMA_OP_MINU 6'h14
`define BMA_OP_SEXTB 6'h15
`define BMA_OP_SEXTH 6'h16
`define BMA_OP_ZEXTH 6'h17
`define BMA_OP_ROL 6'h18
`define BMA_OP_ROLW 6'h19
`define BMA_OP_ROR 6'h1a
`define BMA_OP_RORI 6'h1b
`define BMA_OP_RORIW 6'h1c
`define BMA_OP_RORW 6'h1d
`define BMA_OP_ORCB 6'h1e
`define BMA_OP_REV8 6'h1f
`define BMA_OP_CLMUL 6'h20
`define BMA_OP_CLMULH 6'h21
`define BMA_OP_CLMULR 6'h22
`define BMA_OP_BCLR 6'h23
`define BMA_OP_BCLRI 6'h24
`define BMA_OP_BEXT 6'h25
`define BMA_OP_BEXTI 6'h26
`define BMA_OP_BINV 6'h27
`define BMA_OP_BINVI 6'h28
`define BMA_OP_BSET 6'h29
`define BMA_OP_BSETI 6'h2a
`define BMA_IMMW 7
`endif

// ==== bma_clmul.v ====
`timescale 1ns/1ps
`include "bma_defines.vh"
// Carry-less double-width product
module bma_clmul (
	// Operands
	input wire [63:0] i_a,
	input wire [63:0] i_b,
	input wire i_rv64,
	// Product
	output reg [127:0] o_prod
);
	integer i;
	reg [63:0] a;
	reg [63:0] b;
	always @* begin
		a = i_rv64 ? i_a : {32'h0000_0000, i_a[31:0]};
		b = i_rv64 ? i_b : {32'h0000_0000, i_b[31:0]};
		o_prod = 128'h0000_0000_0000_0000_0000_0000_0000_0000;
		for (i = 0; i < 64; i = i + 1) begin
			if (b[i]) begin
				o_prod = o_prod ^ ({64'h0000_0000_0000_0000, a} << i);
			end
		end
	end
endmodule // bma_clmul

// ==== bma_alu_monitor.sv ====
`timescale 1ns/1ps
`include "bma_defines.vh"
module bma_alu_monitor (
	// Clock and reset
	input wire i_clk,
	input wire i_rst,
	// Request
	input wire i_valid,
	input wire [5:0] i_op,
	input wire i_rv64,
	input wire [63:0] i_rs1,
	input wire [63:0] i_rs2,
	input wire [6:0] i_imm,
	// Result
	input wire o_valid,
	input wire o_illegal,
	input wire [63:0] o_result
);
default clocking @(posedge i_clk); endclocking
default disable iff (i_rst);
property p_lat; i_valid |=> o_valid; endproperty
a_lat: assert property (p_lat) else $error("no result");
property p_idle; !i_valid |=> !o_valid && o_result == 64'h0; endproperty
a_idle: assert property (p_idle) else $error("stray result");
property p_ill; o_illegal |-> o_valid && o_result == 64'h0; endproperty
a_ill: assert property (p_ill) else $error("illegal not zero");
property p_roriw; i_valid && i_op == `BMA_OP_RORIW && !i_rv64 |=> o_illegal; endproperty
a_roriw: assert property (p_roriw) else $error("word rotate taken");
property p_imm; i_valid && i_op == `BMA_OP_RORI && i_imm[6] |=> o_illegal; endproperty
a_imm: assert property (p_imm) else $error("wide shamt taken");
property p_andn;
	i_valid && i_rv64 && !i_imm[6] && i_op == `BMA_OP_ANDN |=> o_result == $past(i_rs1 & ~i_rs2);
endproperty
a_andn: assert property (p_andn) else $error("andn wrong");
property p_sh;
	i_valid && i_rv64 && !i_imm[6] && i_op == `BMA_OP_SH3ADD
		|=> o_result == $past((i_rs1 << 3) + i_rs2);
endproperty
a_sh: assert property (p_sh) else $error("shift add wrong");
property p_word; o_valid && !$past(i_rv64) |-> o_result[63:32] == {32{o_result[31]}}; endproperty
a_word: assert property (p_word) else $error("not sign extended");
c_b2b: cover property (i_valid [*2]);
c_ill: cover property (o_illegal);
c_clm: cover property (i_valid && i_op == `BMA_OP_CLMUL);
endmodule // bma_alu_monitor
bind bma_alu bma_alu_monitor mon_u (.i_clk(i_clk), .i_rst(i_rst), .i_valid(i_valid),
	.i_op(i_op), .i_rv64(i_rv64), .i_rs1(i_rs1), .i_rs2(i_rs2), .i_imm(i_imm),
	.o_valid(o_valid), .o_illegal(o_illegal), .o_result(o_result));

// ==== bma_pipe_model.sv ====
`timescale 1ns/1ps
module bma_pipe_model (
	// Request
	output logic o_valid,
	output logic [5:0] o_op,
	output logic o_rv64,
	output logic [63:0] o_rs1,
	output logic [63:0] o_rs2,
	output logic [6:0] o_imm
);
initial put(1'b0, 6'h00, 1'b1, 64'h0, 64'h0, 7'h00);
task put(input logic v, input logic [5:0] op, input logic w, input logic [63:0] a, b,
		input logic [6:0] m);
	o_valid = v;
	o_op = op;
	o_rv64 = w;
	o_rs1 = a;
	o_rs2 = b;
	o_imm = m;
endtask
endmodule // bma_pipe_model

// ==== tb.sv ====
`timescale 1ns/1ps
`include "bma_defines.vh"
module tb;
logic i_clk = 1'b0;
logic i_rst = 1'b1;
wire v, w, ov, oi;
wire [5:0] op;
wire [63:0] a, b, res;
wire [6:0] im;
int fails = 0;
int comparisons = 0;
logic pend = 1'b0;
logic [64:0] ex = 65'h0;
always #2.5 i_clk = ~i_clk;
bma_pipe_model pipe_u (.o_valid(v), .o_op(op), .o_rv64(w), .o_rs1(a), .o_rs2(b), .o_imm(im));
bma_alu dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_valid(v), .i_op(op), .i_rv64(w), .i_rs1(a),
	.i_rs2(b), .i_imm(im), .o_valid(ov), .o_illegal(oi), .o_result(res));
function automatic logic [63:0] sx(input logic [31:0] x);
	return {{32{x[31]}}, x};
endfunction
function automatic logic [64:0] ref_f(input logic [5:0] o, input logic w, input logic [63:0] x, y,
		input logic [6:0] m);
	logic [63:0] r, sa, sb, e, t, u, v;
	logic [127:0] p;
	logic il;
	int n;
	sa = w ? x : sx(x[31:0]);
	sb = w ? y : sx(y[31:0]);
	e = 64'h1 << (o[0] ? (y[5:0] & {w, 5'h1f}) : m[5:0]);
	t = {x[31:0], x[31:0]};
	u = w ? x : {32'h0, x[31:0]};
	v = w ? y : {32'h0, y[31:0]};
	n = (!w || (o inside {`BMA_OP_CLZW, `BMA_OP_CTZW, `BMA_OP_CPOPW})) ? 32 : 64;
	il = !w && (o inside {[0:0], [4:7], 12, 14, 16, 25, 28, 29});
	il = il || m[6] || (!w && m[5] && (o inside {27, 36, 38, 40, 42})) || (o == 28 && m[5]);
	p = 128'h0;
	r = 64'h0;
	for (int i = 0; i < 64; i++) p ^= v[i] ? ({64'h0, u} << i) : 128'h0;
	case (o)
	`BMA_OP_ADDUW: r = y + {32'h0, x[31:0]};
	1, 2, 3: r = (sa << o[1:0]) + sb;
	4, 5, 6: r = ({32'h0, x[31:0]} << (o - 3)) + y;
	`BMA_OP_SLLIUW: r = {32'h0, x[31:0]} << m[5:0];
	`BMA_OP_ANDN: r = sa & ~sb;
	`BMA_OP_ORN: r = sa | ~sb;
	`BMA_OP_XNOR: r = sa ^ ~sb;
	`BMA_OP_CLZ, `BMA_OP_CLZW: for (int i = 0; i <= n; i++) r = (i == 0 || x[i - 1]) ? n - i : r;
	`BMA_OP_CTZ, `BMA_OP_CTZW: for (int i = n; i >= 0; i--) r = (i == n || x[i]) ? i : r;
	`BMA_OP_CPOP, `BMA_OP_CPOPW: for (int i = 0; i < n; i++) r += x[i];
	`BMA_OP_MAX: r = ($signed(sa) > $signed(sb)) ? sa : sb;
	`BMA_OP_MAXU: r = (sa > sb) ? sa : sb;
	`BMA_OP_MIN: r = ($signed(sa) < $signed(sb)) ? sa : sb;
	`BMA_OP_MINU: r = (sa < sb) ? sa : sb;
	`BMA_OP_SEXTB: r = {{56{x[7]}}, x[7:0]};
	`BMA_OP_SEXTH: r = {{48{x[15]}}, x[15:0]};
	`BMA_OP_ZEXTH: r = {48'h0, x[15:0]};
	`BMA_OP_ROL: r = w ? (x << y[5:0]) | (x >> (64 - y[5:0])) : sx(32'((t << y[4:0]) >> 32));
	`BMA_OP_ROR: r = w ? (x >> y[5:0]) | (x << (64 - y[5:0])) : sx(32'(t >> y[4:0]));
	`BMA_OP_RORI: r = w ? (x >> m[5:0]) | (x << (64 - m[5:0])) : sx(32'(t >> m[4:0]));
	`BMA_OP_ROLW: r = sx(32'((t << y[4:0]) >> 32));
	`BMA_OP_RORW: r = sx(32'(t >> y[4:0]));
	`BMA_OP_RORIW: r = sx(32'(t >> m[4:0]));
	`BMA_OP_ORCB: for (int i = 0; i < 8; i++) r[8*i+:8] = {8{|x[8*i+:8]}};
	`BMA_OP_REV8: for (int i = 0; i < 8; i++) r[8*i+:8] = w ? x[56-8*i+:8] : (i < 4 ? x[24-8*i+:8] : 8'h0);
	`BMA_OP_CLMUL: r = p[63:0];
	`BMA_OP_CLMULH: r = w ? p[127:64] : p[63:32];
	`BMA_OP_CLMULR: r = w ? p[126:63] : p[62:31];
	`BMA_OP_BCLR, `BMA_OP_BCLRI: r = x & ~e;
	`BMA_OP_BEXT, `BMA_OP_BEXTI: r = {63'h0, |(x & e)};
	`BMA_OP_BINV, `BMA_OP_BINVI: r = x ^ e;
	`BMA_OP_BSET, `BMA_OP_BSETI: r = x | e;
	default: il = 1'b1;
	endcase
	r = w ? r : sx(r[31:0]);
	return {il, il ? 64'h0 : r};
endfunction
function automatic logic [63:0] rnd();
	return ($urandom % 3 == 0) ? 64'h8000_0000_ffff_ffff : {$urandom, $urandom};
endfunction
////////////////////////////////////////////////////////////////////////////////
task automatic step(input logic q, input logic [5:0] o, input logic w, input logic [63:0] x, y,
		input logic [6:0] m);
	@(posedge i_clk);
	#1;
	comparisons++;
	if (pend ? (ov !== 1'b1 || {oi, res} !== ex) : (ov !== 1'b0)) begin
		fails++;
		$display("BAD %0t got %b %h want %h", $time, ov, res, ex);
	end
	pend = q;
	ex = ref_f(o, w, x, y, m);
	pipe_u.put(q, o, w, x, y, m);
endtask
task automatic results();
	$display("counts: comparisons %0d fails %0d", comparisons, fails);
	if (fails == 0 && comparisons > 0) begin
		$display("RESULT: PASS");
	end else begin
		$display("RESULT: FAIL");
	end
	$finish;
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
	logic [5:0] o;
	logic w;
	void'($urandom(32'h5759_9ed1));
	repeat (16) @(posedge i_clk);
	#1;
	i_rst = 1'b0;
	step(1, `BMA_OP_RORIW, 0, 64'h1, 64'h0, 7'h01);
	step(1, `BMA_OP_RORI, 1, 64'h1, 64'h0, 7'h40);
	step(1, `BMA_OP_ORCB, 1, 64'h0001_0000_8000_0000, 64'h0, 7'h00);
	step(1, `BMA_OP_CLZ, 1, 64'h0, 64'h0, 7'h00);
	step(1, `BMA_OP_ROL, 1, 64'h8000_0000_0000_0001, 64'hffff_ffff_ffff_ffc1, 7'h00);
	step(1, `BMA_OP_SH2ADDUW, 1, 64'hffff_ffff_0000_0002, 64'h0100, 7'h00);
	step(1, `BMA_OP_CLMULR, 1, 64'h8000_0000_0000_0001, 64'h0003, 7'h00);
	step(1, 6'h3f, 1, 64'h1, 64'h1, 7'h00);
	step(0, 6'h00, 1, 64'h0, 64'h0, 7'h00);
	$display("test corners done");
	for (int k = 0; k < 3000; k++) begin
		o = 6'($urandom_range(0, 47));
		w = 1'($urandom);
		step($urandom % 4 != 0, o, w, rnd(), rnd(), {1'b0, o != 6'h1c && 1'($urandom), 5'($urandom)});
	end
	step(0, 6'h00, 1, 64'h0, 64'h0, 7'h00);
	$display("test random done");
	results();
end
endmodule // tb
